// File: verilog/radio_sleep_params.svh
// Offsets, field positions, reset values and counts for the radio sleep control registers
`ifndef RADIO_SLEEP_PARAMS_SVH
`define RADIO_SLEEP_PARAMS_SVH

// Register byte addresses
`define ADDR_SYSTEM_MISC_CONTROL 32'h5000_3308
`define ADDR_SLEEP_COUNTER_SNAPSHOT 32'h5000_330A

// Widths
`define REG_WIDTH 16
`define ADDR_WIDTH 32
`define FINE_WIDTH 10
`define SLEEP_TIME_WIDTH 19

// Control register field positions
`define CTRL_WAKE_REQ_BIT 0
`define CTRL_IRQ_LEVEL_BIT 2
`define CTRL_PRIORITY_BIT 4
`define CTRL_SELECT_LSB 5
`define CTRL_SELECT_MSB 6

// Snapshot register field positions
`define SNAP_LSB 0
`define SNAP_MSB 9

// Reset values
`define CTRL_RESET 16'h0000
`define SNAP_RESET 10'h000
`define SELECT_RESET 2'h0
`define PRIORITY_RESET 1'b0
`define WAKE_REQ_RESET 1'b0

// Wake-up interrupt is raised on this low-power clock edge after the request
`define WAKE_LP_EDGES 3'h4

`endif

// File: verilog/radio_sleep_pkg.sv
// Types shared by the radio sleep control registers
package radio_sleep_pkg;

    // Source returned by a snapshot register read
    typedef enum logic [1:0] {
        SEL_SNAPSHOT,
        SEL_DURATION,
        SEL_TIME_LOW,
        SEL_TIME_HIGH
    } read_select_e;

    // Wake-up delay sequencer states
    typedef enum logic [1:0] {
        WAKE_IDLE,
        WAKE_COUNT,
        WAKE_RAISED
    } wake_state_e;

endpackage

// File: verilog/radio_wakeup_timer.sv
// Wake-up delay sequencer counted in low-power clock edges
`timescale 1ns/1ps
`default_nettype none
`include "radio_sleep_params.svh"

module radio_wakeup_timer (
    // System clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Low-power clock level, sampled on clk_sys
    input wire logic lpClk,
    // Radio core state and request
    input wire logic radioDeepSleep,
    input wire logic radioWakeupRequest,
    // Wake-up interrupt level
    output logic radioWakeupIrqLevel
);
    import radio_sleep_pkg::*;

    logic lpClkPrev;
    logic lpEdge;
    logic [2:0] edgeCount;
    wake_state_e state;

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            lpClkPrev <= 1'b0;
        end else begin
            lpClkPrev <= lpClk;
        end
    end

    assign lpEdge = lpClk & ~lpClkPrev;

    ////////////////////////////////////////////////////////////////////////
    // Request phase against the slow clock is arbitrary; counting four rising
    // edges after it lands the interrupt between three and four periods later
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state <= WAKE_IDLE;
            edgeCount <= 3'h0;
        end else begin
            case (state)
                WAKE_IDLE: begin
                    edgeCount <= 3'h0;
                    if (radioDeepSleep && radioWakeupRequest) begin
                        state <= WAKE_COUNT;
                    end
                end
                WAKE_COUNT: begin
                    if (!radioDeepSleep) begin
                        state <= WAKE_IDLE;
                    end else if (lpEdge) begin
                        edgeCount <= edgeCount + 3'h1;
                        if (edgeCount + 3'h1 == `WAKE_LP_EDGES) begin
                            state <= WAKE_RAISED;
                        end
                    end
                end
                WAKE_RAISED: begin
                    // Level holds until the core has left deep sleep
                    if (!radioDeepSleep) begin
                        state <= WAKE_IDLE;
                    end
                end
                default: begin
                    state <= WAKE_IDLE;
                end
            endcase
        end
    end

    assign radioWakeupIrqLevel = (state == WAKE_RAISED);

endmodule // radio_wakeup_timer

`default_nettype wire

// File: verilog/radio_sleep_control_regs.sv
// Radio sleep control registers: bus priority, wake-up request and fine counter snapshot
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "radio_sleep_params.svh"

module radio_sleep_control_regs (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Register port
    input wire logic [`ADDR_WIDTH-1:0] regAddr,
    input wire logic [`REG_WIDTH-1:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [`REG_WIDTH-1:0] regRdData,
    // System bus arbitration
    output logic busMasterPriority,
    // Low-power clock level
    input wire logic lpClk,
    // Radio core sleep handshake
    input wire logic radioDeepSleep,
    input wire logic sleepEntry,
    input wire logic wakeRestore,
    output logic radioWakeupRequest,
    output logic radioWakeupIrqLevel,
    // Fine counter capture and restore
    input wire logic [`FINE_WIDTH-1:0] fineSlotCounter,
    output logic [`FINE_WIDTH-1:0] fineSlotRestore,
    output logic fineSlotLoad,
    // Sleep timer quantities for alternate reads
    input wire logic [`FINE_WIDTH-1:0] sleepDuration,
    input wire logic [`SLEEP_TIME_WIDTH-1:0] sleepTimeSample,
    input wire logic sleepStatMonitor
);
    import radio_sleep_pkg::*;

    logic [1:0] snapshotReadSelect;
    logic [`FINE_WIDTH-1:0] snapshot;
    logic [`FINE_WIDTH-1:0] snapWriteData;
    logic snapWritePending;
    logic ctrlHit;
    logic snapHit;
    logic [`REG_WIDTH-1:0] ctrlView;
    logic [`FINE_WIDTH-1:0] snapView;
    logic [`REG_WIDTH-1:0] next_regRdData;

    ////////////////////////////////////////////////////////////////////////
    // Address decode
    always_comb begin
        ctrlHit = 1'b0;
        snapHit = 1'b0;
        if (regAddr == `ADDR_SYSTEM_MISC_CONTROL) begin
            ctrlHit = 1'b1;
        end else if (regAddr == `ADDR_SLEEP_COUNTER_SNAPSHOT) begin
            snapHit = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control register writable fields
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            busMasterPriority <= `PRIORITY_RESET;
            radioWakeupRequest <= `WAKE_REQ_RESET;
            snapshotReadSelect <= `SELECT_RESET;
        end else if (regWrite && ctrlHit) begin
            busMasterPriority <= regWrData[`CTRL_PRIORITY_BIT];
            // Holding time against the slow clock is left to software
            radioWakeupRequest <= regWrData[`CTRL_WAKE_REQ_BIT];
            snapshotReadSelect <= regWrData[`CTRL_SELECT_MSB:`CTRL_SELECT_LSB];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Wake-up delay sequencer
    radio_wakeup_timer wakeTimer (
        .clk_sys(clk_sys),
        .rst(rst),
        .lpClk(lpClk),
        .radioDeepSleep(radioDeepSleep),
        .radioWakeupRequest(radioWakeupRequest),
        .radioWakeupIrqLevel(radioWakeupIrqLevel)
    );

    ////////////////////////////////////////////////////////////////////////
    // Snapshot writes are committed one cycle late, so a read right behind a
    // write still sees the old value; the select field plays no part here
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            snapWritePending <= 1'b0;
            snapWriteData <= `SNAP_RESET;
        end else begin
            snapWritePending <= regWrite && snapHit;
            snapWriteData <= regWrData[`SNAP_MSB:`SNAP_LSB];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Snapshot store; hardware capture wins over a pending software write (strobed one cycle earlier) committing in the same cycle
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            snapshot <= `SNAP_RESET;
        end else if (sleepEntry) begin
            snapshot <= fineSlotCounter;
        end else if (snapWritePending) begin
            // Awake writes only touch this copy, never the core
            snapshot <= snapWriteData;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Restore toward the core happens only on the wake-up sequence
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            fineSlotLoad <= 1'b0;
            fineSlotRestore <= `SNAP_RESET;
        end else begin
            fineSlotLoad <= wakeRestore;
            if (wakeRestore) begin
                fineSlotRestore <= snapshot;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read views
    always_comb begin
        ctrlView = `CTRL_RESET;
        ctrlView[`CTRL_WAKE_REQ_BIT] = radioWakeupRequest;
        ctrlView[`CTRL_IRQ_LEVEL_BIT] = radioWakeupIrqLevel;
        ctrlView[`CTRL_PRIORITY_BIT] = busMasterPriority;
        ctrlView[`CTRL_SELECT_MSB:`CTRL_SELECT_LSB] = snapshotReadSelect;
    end

    always_comb begin
        case (read_select_e'(snapshotReadSelect))
            SEL_DURATION: snapView = sleepDuration;
            SEL_TIME_LOW: snapView = sleepTimeSample[`FINE_WIDTH-1:0];
            SEL_TIME_HIGH: snapView = {sleepStatMonitor, sleepTimeSample[`SLEEP_TIME_WIDTH-1:`FINE_WIDTH]};
            default: snapView = snapshot;
        endcase
    end

    always_comb begin
        next_regRdData = 16'h0000;
        if (ctrlHit) begin
            next_regRdData = ctrlView;
        end else if (snapHit) begin
            next_regRdData = {6'h00, snapView};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data stand only in the cycle after the strobe
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            regRdData <= 16'h0000;
        end else if (regRead) begin
            regRdData <= next_regRdData;
        end else begin
            regRdData <= 16'h0000;
        end
    end

endmodule // radio_sleep_control_regs

`default_nettype wire

// File: tb/radio_sleep_control_regs_properties.sv
// Assertions for the radio sleep control registers
`timescale 1ns/1ps
`default_nettype none
`include "radio_sleep_params.svh"
module radio_sleep_control_regs_properties (
    // Clock, reset and register port
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [31:0] regAddr,
    input wire logic [15:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [15:0] regRdData,
    // Radio side
    input wire logic busMasterPriority,
    input wire logic radioDeepSleep,
    input wire logic sleepEntry,
    input wire logic wakeRestore,
    input wire logic radioWakeupIrqLevel,
    input wire logic [9:0] fineSlotCounter,
    input wire logic [9:0] fineSlotRestore,
    input wire logic fineSlotLoad,
    input wire logic [9:0] sleepDuration
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    logic [1:0] sel;
    logic ctlWr, ctlRd, snpWr, snpRd;
    assign ctlWr = regWrite && regAddr == `ADDR_SYSTEM_MISC_CONTROL;
    assign ctlRd = regRead && regAddr == `ADDR_SYSTEM_MISC_CONTROL;
    assign snpWr = regWrite && regAddr == `ADDR_SLEEP_COUNTER_SNAPSHOT;
    assign snpRd = regRead && regAddr == `ADDR_SLEEP_COUNTER_SNAPSHOT;
    // Select tracked here so read checks need no access to the body
    always_ff @(posedge clk_sys) begin
        if (rst) sel <= 2'h0;
        else if (ctlWr) sel <= regWrData[6:5];
    end
    sequence captureThenRestore;
        sleepEntry && !regWrite ##1 !sleepEntry && !wakeRestore && !regWrite ##1 wakeRestore && !sleepEntry && !regWrite;
    endsequence
    sequence writeThenRestore;
        snpWr && !sleepEntry ##1 !regWrite && !sleepEntry ##1 wakeRestore && !sleepEntry && !regWrite;
    endsequence
    AST_PRIORITY: assert property (ctlWr |=> busMasterPriority == $past(regWrData[4]))
        else $error("priority bit not taken from write");
    AST_IRQ_READ: assert property (ctlRd |=> regRdData[2] == $past(radioWakeupIrqLevel))
        else $error("status bit differs from wake-up level");
    AST_IRQ_RISE: assert property ($rose(radioWakeupIrqLevel) |-> $past(radioDeepSleep))
        else $error("wake-up level rose outside deep sleep");
    AST_CAPTURE: assert property (captureThenRestore |=> fineSlotLoad && fineSlotRestore == $past(fineSlotCounter, 3))
        else $error("restored value is not the captured counter");
    AST_SW_RESTORE: assert property (writeThenRestore |=> fineSlotRestore == $past(regWrData[9:0], 3))
        else $error("restored value is not the written snapshot");
    AST_LOAD_CAUSE: assert property (!wakeRestore |=> !fineSlotLoad)
        else $error("counter load without restore");
    AST_CTRL_RESERVED: assert property (ctlRd |=> (regRdData & 16'hFF8A) == 16'h0000)
        else $error("reserved control bits not zero");
    AST_SEL_DURATION: assert property (snpRd && sel == 2'h1 |=> regRdData == {6'h00, $past(sleepDuration)})
        else $error("select one read wrong");
endmodule // radio_sleep_control_regs_properties
bind radio_sleep_control_regs radio_sleep_control_regs_properties i_props (.*);
`default_nettype wire

// File: tb/radio_link_model.sv
// Link-layer core stand-in: slow clock, sleep handshake and fine counter
`timescale 1ns/1ps
`default_nettype none
module radio_link_model #(parameter int LP_HALF = 4) (
    // System clock
    input wire logic clk_sys,
    // Sleep handshake
    output logic lpClk,
    output logic radioDeepSleep,
    output logic sleepEntry,
    output logic wakeRestore,
    // Fine counter
    output logic [9:0] fineSlotCounter,
    input wire logic fineSlotLoad,
    input wire logic [9:0] fineSlotRestore
);
    int lpCount = 0;
    initial begin
        lpClk = 1'b0;
        radioDeepSleep = 1'b0;
        sleepEntry = 1'b0;
        wakeRestore = 1'b0;
        fineSlotCounter = 10'h000;
    end
    // Slow clock runs free; far faster than in silicon to keep the run short
    always @(posedge clk_sys) begin
        lpCount <= (lpCount == LP_HALF - 1) ? 0 : lpCount + 1;
        if (lpCount == LP_HALF - 1) lpClk <= !lpClk;
    end
    // Counter frozen in sleep, reloaded on wake-up
    always @(posedge clk_sys) begin
        if (fineSlotLoad) fineSlotCounter <= fineSlotRestore;
        else if (!radioDeepSleep && !sleepEntry) fineSlotCounter <= fineSlotCounter + 10'h001;
    end
    task automatic enter;
        @(posedge clk_sys);
        sleepEntry <= 1'b1;
        radioDeepSleep <= 1'b1;
        @(posedge clk_sys);
        sleepEntry <= 1'b0;
    endtask
    task automatic leave;
        @(posedge clk_sys);
        wakeRestore <= 1'b1;
        @(posedge clk_sys);
        wakeRestore <= 1'b0;
        radioDeepSleep <= 1'b0;
    endtask
endmodule // radio_link_model
`default_nettype wire

// File: tb/radio_sleep_control_regs_test.sv
// Self-checking bench for the radio sleep control registers
`timescale 1ns/1ps
`default_nettype none
`include "radio_sleep_params.svh"
module radio_sleep_control_regs_test;
    localparam int LP_HALF = 4;
    logic clk_sys, rst, regWrite, regRead, busMasterPriority, lpClk, radioDeepSleep, sleepEntry, wakeRestore;
    logic radioWakeupRequest, radioWakeupIrqLevel, fineSlotLoad, sleepStatMonitor;
    logic [31:0] regAddr;
    logic [15:0] regWrData, regRdData, want;
    logic [9:0] fineSlotCounter, fineSlotRestore, sleepDuration, snap;
    logic [18:0] sleepTimeSample;
    int fails = 0;
    int numChecks = 0;
    int seed = 32'h84e0;
    int n;
    radio_sleep_control_regs i_radio_sleep_control_regs (.*);
    radio_link_model #(.LP_HALF(LP_HALF)) i_radio_link_model (.*);
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = !clk_sys;
    end
    ////////////////////////////////////////
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        numChecks++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // A write ends with an idle cycle, so a read-back always sees new data
    task automatic wr(input logic [31:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        regAddr <= a;
        regWrData <= d;
        regWrite <= 1'b1;
        @(posedge clk_sys);
        regWrite <= 1'b0;
    endtask
    task automatic rd(input logic [31:0] a);
        @(posedge clk_sys);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk_sys);
        regRead <= 1'b0;
        @(negedge clk_sys);
    endtask
    task automatic giveVerdict;
        $display("Checks %0d mismatches %0d", numChecks, fails);
        if (fails == 0 && numChecks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    ////////////////////////////////////////
    initial begin
        rst = 1'b1;
        regWrite = 1'b0;
        regRead = 1'b0;
        regAddr = 32'h0000_0000;
        regWrData = 16'h0000;
        sleepDuration = 10'($random(seed));
        sleepTimeSample = 19'($random(seed));
        sleepStatMonitor = 1'b1;
        repeat (20) @(posedge clk_sys);
        rst <= 1'b0;
        rd(`ADDR_SYSTEM_MISC_CONTROL);
        check("ctrlReset", regRdData, 16'h0000);
        rd(`ADDR_SLEEP_COUNTER_SNAPSHOT);
        check("snapReset", regRdData, 16'h0000);
        wr(`ADDR_SYSTEM_MISC_CONTROL, 16'hFFFE);
        rd(`ADDR_SYSTEM_MISC_CONTROL);
        check("ctrlMask", regRdData, 16'h0070);
        check("prio", 16'(busMasterPriority), 16'h0001);
        rd(32'h5000_330C);
        check("unmapped", regRdData, 16'h0000);
        for (int s = 0; s < 4; s++) begin
            wr(`ADDR_SYSTEM_MISC_CONTROL, 16'(s << 5));
            snap = 10'($random(seed));
            wr(`ADDR_SLEEP_COUNTER_SNAPSHOT, {6'h3F, snap});
            rd(`ADDR_SLEEP_COUNTER_SNAPSHOT);
            want = s == 0 ? {6'h00, snap} : s == 1 ? {6'h00, sleepDuration} :
                s == 2 ? {6'h00, sleepTimeSample[9:0]} : {6'h00, sleepStatMonitor, sleepTimeSample[18:10]};
            check("snapSelect", regRdData, want);
        end
        wr(`ADDR_SYSTEM_MISC_CONTROL, 16'h0000);
        rd(`ADDR_SLEEP_COUNTER_SNAPSHOT);
        check("snapAfterSelect", regRdData, {6'h00, snap});
        i_radio_link_model.enter();
        rd(`ADDR_SLEEP_COUNTER_SNAPSHOT);
        check("capture", regRdData, {6'h00, fineSlotCounter});
        wr(`ADDR_SYSTEM_MISC_CONTROL, 16'h0001);
        n = 0;
        while (radioWakeupIrqLevel !== 1'b1 && n < 200) begin
            @(negedge clk_sys);
            n++;
        end
        // A timeout counts as a mismatch and the run still reaches the single verdict
        if (n == 200) begin
            fails++;
        end
        check("wakeDelay", 16'(n >= 6 * LP_HALF && n <= 8 * LP_HALF + 3), 16'h0001);
        rd(`ADDR_SYSTEM_MISC_CONTROL);
        check("irqBit", regRdData, 16'h0005);
        wr(`ADDR_SYSTEM_MISC_CONTROL, 16'h0000);
        snap = 10'($random(seed));
        wr(`ADDR_SLEEP_COUNTER_SNAPSHOT, {6'h00, snap});
        i_radio_link_model.leave();
        @(negedge clk_sys);
        check("restore", {5'h00, fineSlotLoad, fineSlotRestore}, {6'h01, snap});
        rd(`ADDR_SYSTEM_MISC_CONTROL);
        check("irqAwake", regRdData, 16'h0000);
        // Sleep and wake back to back: the captured count must come straight back
        i_radio_link_model.enter();
        snap = fineSlotCounter;
        i_radio_link_model.leave();
        @(negedge clk_sys);
        check("captureRestore", {5'h00, fineSlotLoad, fineSlotRestore}, {6'h01, snap});
        giveVerdict();
    end
endmodule // radio_sleep_control_regs_test
`default_nettype wire
